// ---- acs_defs.svh ----
// Purpose: Offsets, field positions, reset values and codes of the sequencer control block.
// Assumes: APB registers, one aligned 32-bit word each.
// Notes:   Included by the top module acs_top only.
//
// What this block does
// - Differential field value i selects inputs 2i and 2i+1 for lower four pairs.
// - Upper pairs use field values 0x8 to 0xB for pair indices 4 to 7.
// - Retrigger before sequence end makes the sequencer sample continuously, step interrupts continue.
// - Continuous sampling happens only when the retrigger has the starting trigger type.
// - Comparator on a sequence's last step gives neither trigger nor interrupt.
// - Sequencer three has exactly one step, always the last.
// - Result of step n is judged by step n+1's comparator setting.
// - Processor sequence followed by other trigger type occasionally loses its interrupt.
// - With two and three pending only, arbiter compares one against two.
// - Each sequencer has a priority 0 (highest) to 3 (lowest).
// - Sample phase control register is stored but never affects sampling.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ACS_OFF_ENABLE   8'h00
`define ACS_OFF_STATUS   8'h04
`define ACS_OFF_INTEN    8'h08
`define ACS_OFF_INTCLR   8'h0C
`define ACS_OFF_TRIGSEL  8'h10
`define ACS_OFF_PROCINIT 8'h14
`define ACS_OFF_PRIORITY 8'h18
`define ACS_OFF_PHASE    8'h1C
`define ACS_OFF_THRESH   8'h20
`define ACS_OFF_SEQ_BASE 8'h40
`define ACS_OFF_SEQ_CTL  8'h04

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ACS_CTL_IE_POS   8
`define ACS_CTL_LEN_POS  16
`define ACS_CTL_CMP_POS  24
`define ACS_THR_MODE_POS 16
`define ACS_PRI_RESET    8'hE4
`define ACS_LEN_MAX      12'h337
`define ACS_TRIG_PROC    3'h0
`define ACS_TRIG_COMP    3'h1
`define ACS_TRIG_EXT     3'h2
`define ACS_TRIG_TIMER   3'h3
`define ACS_TRIG_PWM     3'h4
`define ACS_DROP_PHASE   2'h3

`endif

// ---- acs_pkg.sv ----
// Purpose: Types shared by the sequencer control modules.
// Assumes: Constants come from acs_defs.svh.
// Notes:   Types only.
`default_nettype none
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_ISSUE,
        ACS_WAIT
    } acs_state_e;
    typedef logic [11:0] acs_sample_t;
endpackage
`default_nettype wire

// ---- acs_cmp_if.sv ----
// Purpose: Carries one sample and its comparator setting to the comparator unit.
// Assumes: Same clock on both ends.
// Notes:   Purely combinational link.
`default_nettype none
interface acs_cmp_if;
    import acs_pkg::*;
    logic        valid;
    acs_sample_t data;
    acs_sample_t thresh;
    logic        below;
    logic        fire;
    modport eng  (output valid, output data, output thresh, output below, input fire);
    modport unit (input valid, input data, input thresh, input below, output fire);
endinterface
`default_nettype wire

// ---- acs_dcmp.sv ----
// Purpose: Digital comparator judging one conversion result against a threshold.
// Assumes: The engine has already chosen which step's setting applies.
// Notes:   Fires for results at or above the threshold, or below it in below mode.
`default_nettype none
module acs_dcmp
    import acs_pkg::*;
(
    acs_cmp_if.unit cmp
);
    always_comb begin
        cmp.fire = cmp.valid && (cmp.below ? (cmp.data < cmp.thresh) : (cmp.data >= cmp.thresh));
    end
endmodule
`default_nettype wire

// ---- acs_top.sv ----
// Purpose: Sample sequencer control: triggers, arbitration, step engine, comparators, interrupts.
// Assumes: The converter core runs on pclk and answers conv_start with one conv_done pulse.
// Notes:   Registers over APB; all outputs are registered.
`include "acs_defs.svh"
`default_nettype none
module acs_top
    import acs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        comp_trig_in,
    input  wire logic        ext_trig_pin,
    input  wire logic        timer_trig,
    input  wire logic        pwm_trigger,
    output logic             conv_start,
    output logic      [3:0]  conv_pos,
    output logic      [3:0]  conv_neg,
    output logic             conv_diff,
    input  wire logic        conv_done,
    input  wire acs_sample_t conv_data,
    output acs_sample_t      result_data,
    output logic      [1:0]  result_seq,
    output logic             result_valid,
    output logic      [3:0]  comparator_trigger,
    output logic             irq
);
    // ----------------------------------------------------------------
    // Register file state
    // ----------------------------------------------------------------
    logic [3:0]  seq_en, next_seq_en;
    logic [7:0]  status, next_status;
    logic [7:0]  int_en, next_int_en;
    logic [15:0] trigsel, next_trigsel;
    logic [7:0]  pri, next_pri;
    logic [31:0] sample_phase_control_reg, next_phase;
    logic [16:0] thresh, next_thresh;
    logic [31:0] sequence_input_select_reg [4];
    logic [31:0] next_mux [4];
    logic [31:0] seq_ctl [4];
    logic [31:0] next_ctl [4];
    logic [3:0]  proc_init;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr, next_irq;

    // ----------------------------------------------------------------
    // Engine state
    // ----------------------------------------------------------------
    acs_state_e  state, next_state;
    logic [3:0]  pend, next_pend;
    logic [3:0]  cont, next_cont;
    logic [1:0]  cur, next_cur;
    logic [2:0]  step, next_step;
    logic [2:0]  start_type, next_start_type;
    logic [1:0]  drop_ctr, next_drop_ctr;
    logic        next_conv_start, next_conv_diff, next_result_valid;
    logic [3:0]  next_conv_pos, next_conv_neg, next_comp_trig;
    acs_sample_t next_result_data;
    logic [1:0]  next_result_seq;
    logic [2:0]  ext_sync;

    logic        access, wr, mapped;
    logic [3:0]  hit, seq_evt, cmp_evt;
    logic [4:0]  src;
    logic [2:0]  last_step, cur_type;
    logic [3:0]  field;
    logic        step_done, drop, retrig;
    logic [1:0]  grant;
    acs_cmp_if   cmp ();

    acs_dcmp u_dcmp (
        .cmp (cmp)
    );

    assign access = psel && penable && pready;
    assign wr     = access && pwrite;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    always_comb begin
        next_seq_en  = seq_en;
        next_int_en  = int_en;
        next_trigsel = trigsel;
        next_pri     = pri;
        next_phase   = sample_phase_control_reg;
        next_thresh  = thresh;
        next_mux     = sequence_input_select_reg;
        next_ctl     = seq_ctl;
        proc_init    = 4'h0;
        // Hardware events win over a clear in the same cycle.
        next_status  = status;
        if (wr && paddr == `ACS_OFF_INTCLR) begin
            next_status = status & ~pwdata[7:0];
        end
        next_status = next_status | {cmp_evt, seq_evt};
        if (wr) begin
            case (paddr)
                `ACS_OFF_ENABLE:   next_seq_en  = pwdata[3:0];
                `ACS_OFF_INTEN:    next_int_en  = pwdata[7:0];
                `ACS_OFF_TRIGSEL:  next_trigsel = pwdata[15:0];
                `ACS_OFF_PROCINIT: proc_init    = pwdata[3:0];
                `ACS_OFF_PRIORITY: next_pri     = pwdata[7:0];
                `ACS_OFF_PHASE:    next_phase   = pwdata;
                `ACS_OFF_THRESH:   next_thresh  = pwdata[16:0];
                default: begin
                end
            endcase
            for (int s = 0; s < 4; s++) begin
                if (paddr == `ACS_OFF_SEQ_BASE + 8'(8 * s)) begin
                    next_mux[s] = pwdata;
                end
                if (paddr == `ACS_OFF_SEQ_BASE + 8'(8 * s) + `ACS_OFF_SEQ_CTL) begin
                    next_ctl[s] = pwdata;
                end
            end
        end
        mapped = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `ACS_OFF_ENABLE:   next_prdata = {28'h0, seq_en};
            `ACS_OFF_STATUS:   next_prdata = {24'h0, status};
            `ACS_OFF_INTEN:    next_prdata = {24'h0, int_en};
            `ACS_OFF_INTCLR:   next_prdata = 32'h0000_0000;
            `ACS_OFF_TRIGSEL:  next_prdata = {16'h0, trigsel};
            `ACS_OFF_PROCINIT: next_prdata = {28'h0, pend};
            `ACS_OFF_PRIORITY: next_prdata = {24'h0, pri};
            `ACS_OFF_PHASE:    next_prdata = sample_phase_control_reg;
            `ACS_OFF_THRESH:   next_prdata = {15'h0, thresh};
            default: begin
                mapped = 1'b0;
                for (int s = 0; s < 4; s++) begin
                    if (paddr == `ACS_OFF_SEQ_BASE + 8'(8 * s)) begin
                        next_prdata = sequence_input_select_reg[s];
                        mapped = 1'b1;
                    end
                    if (paddr == `ACS_OFF_SEQ_BASE + 8'(8 * s) + `ACS_OFF_SEQ_CTL) begin
                        next_prdata = seq_ctl[s];
                        mapped = 1'b1;
                    end
                end
            end
        endcase
        if (!(psel && !penable) || pwrite) begin
            next_prdata = 32'h0000_0000;
        end
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        next_irq     = |(next_status & int_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_en  <= 4'h0;
            status  <= 8'h00;
            int_en  <= 8'h00;
            trigsel <= 16'h0000;
            pri     <= `ACS_PRI_RESET;
            sample_phase_control_reg <= 32'h0000_0000;
            thresh  <= 17'h0_0000;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
            for (int s = 0; s < 4; s++) begin
                sequence_input_select_reg[s] <= 32'h0000_0000;
                seq_ctl[s] <= 32'h0000_0000;
            end
        end else if (ce) begin
            seq_en  <= next_seq_en;
            status  <= next_status;
            int_en  <= next_int_en;
            trigsel <= next_trigsel;
            pri     <= next_pri;
            sample_phase_control_reg <= next_phase;
            thresh  <= next_thresh;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            irq     <= next_irq;
            sequence_input_select_reg <= next_mux;
            seq_ctl <= next_ctl;
        end
    end

    // ----------------------------------------------------------------
    // Trigger sources and arbitration
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync <= 3'h0;
        end else if (ce) begin
            ext_sync <= {ext_sync[1:0], ext_trig_pin};
        end
    end

    always_comb begin
        for (int s = 0; s < 4; s++) begin
            src = {pwm_trigger, timer_trig, ext_sync[1] && !ext_sync[2], comp_trig_in, proc_init[s]};
            hit[s] = seq_en[s] && trigsel[4 * s +: 3] <= `ACS_TRIG_PWM && src[trigsel[4 * s +: 3]];
        end
        // The crippled compare of one against two, only seen with two and three pending.
        if (pend == 4'hC) begin
            grant = (pri[3:2] < pri[5:4]) ? 2'd2 : 2'd3;
        end else begin
            grant = 2'd3;
            for (int s = 3; s >= 0; s--) begin
                if (pend[s] && (!pend[grant] || pri[2 * s +: 2] <= pri[2 * grant +: 2])) begin
                    grant = 2'(s);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Step engine
    // ----------------------------------------------------------------
    always_comb begin
        cur_type  = trigsel[4 * cur +: 3];
        last_step = seq_ctl[cur][`ACS_CTL_LEN_POS +: 3];
        // One nibble per sequencer holds its highest step index; sequencer three has none above 0.
        if (last_step > 3'(`ACS_LEN_MAX >> (4 * cur))) begin
            last_step = 3'(`ACS_LEN_MAX >> (4 * cur));
        end
        field     = sequence_input_select_reg[cur][4 * step +: 4];
        step_done = state == ACS_WAIT && conv_done;
        retrig    = state != ACS_IDLE && hit[cur] && cur_type == start_type;
        // The engine assigns step n's result to step n+1's comparator; the last has none.
        cmp.valid  = step_done && step != last_step && seq_ctl[cur][`ACS_CTL_CMP_POS + 32'(step) + 1];
        cmp.data   = conv_data;
        cmp.thresh = thresh[11:0];
        cmp.below  = thresh[`ACS_THR_MODE_POS];
        drop = start_type == `ACS_TRIG_PROC && drop_ctr == `ACS_DROP_PHASE;
        drop = drop && |(pend & ~{trigsel[12 +: 3] == `ACS_TRIG_PROC, trigsel[8 +: 3] == `ACS_TRIG_PROC,
                                  trigsel[4 +: 3] == `ACS_TRIG_PROC, trigsel[0 +: 3] == `ACS_TRIG_PROC});
        seq_evt = 4'h0;
        cmp_evt = 4'h0;
        if (step_done && seq_ctl[cur][`ACS_CTL_IE_POS + 32'(step)] && !drop) begin
            seq_evt[cur] = 1'b1;
        end
        if (cmp.fire) begin
            cmp_evt[cur] = 1'b1;
        end

        next_state = state;
        next_cur = cur;
        next_step = step;
        next_start_type = start_type;
        next_drop_ctr = drop_ctr;
        next_cont = (cont | (retrig ? 4'(1) << cur : 4'h0)) & seq_en;
        next_pend = (pend | (retrig ? hit & ~(4'(1) << cur) : hit)) & seq_en;
        next_conv_start = 1'b0;
        next_conv_pos = conv_pos;
        next_conv_neg = conv_neg;
        next_conv_diff = conv_diff;
        next_result_valid = 1'b0;
        next_result_data = result_data;
        next_result_seq = result_seq;
        next_comp_trig = cmp_evt;
        case (state)
            ACS_IDLE: begin
                if (|pend) begin
                    next_cur = grant;
                    next_step = 3'h0;
                    next_start_type = trigsel[4 * grant +: 3];
                    next_pend[grant] = hit[grant];
                    next_state = ACS_ISSUE;
                end
            end
            ACS_ISSUE: begin
                next_conv_start = 1'b1;
                next_conv_diff = seq_ctl[cur][step];
                if (seq_ctl[cur][step]) begin
                    next_conv_pos = {field[3], field[1:0], 1'b0};
                    next_conv_neg = {field[3], field[1:0], 1'b1};
                end else begin
                    next_conv_pos = field;
                    next_conv_neg = 4'h0;
                end
                next_state = ACS_WAIT;
            end
            ACS_WAIT: begin
                if (conv_done) begin
                    next_result_valid = 1'b1;
                    next_result_data = conv_data;
                    next_result_seq = cur;
                    if (seq_ctl[cur][`ACS_CTL_IE_POS + 32'(step)]) begin
                        next_drop_ctr = drop_ctr + 2'd1;
                    end
                    if (step != last_step) begin
                        next_step = step + 3'd1;
                        next_state = ACS_ISSUE;
                    end else if (next_cont[cur]) begin
                        next_step = 3'h0;
                        next_state = ACS_ISSUE;
                    end else begin
                        next_state = ACS_IDLE;
                    end
                end
            end
            default: next_state = ACS_IDLE;
        endcase
        if (!seq_en[cur] && state != ACS_IDLE && !conv_done) begin
            next_state = (state == ACS_WAIT) ? ACS_WAIT : ACS_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ACS_IDLE;
            pend <= 4'h0;
            cont <= 4'h0;
            cur <= 2'h0;
            step <= 3'h0;
            start_type <= 3'h0;
            drop_ctr <= 2'h0;
            conv_start <= 1'b0;
            conv_pos <= 4'h0;
            conv_neg <= 4'h0;
            conv_diff <= 1'b0;
            result_valid <= 1'b0;
            result_data <= 12'h000;
            result_seq <= 2'h0;
            comparator_trigger <= 4'h0;
        end else if (ce) begin
            state <= next_state;
            pend <= next_pend;
            cont <= next_cont;
            cur <= next_cur;
            step <= next_step;
            start_type <= next_start_type;
            drop_ctr <= next_drop_ctr;
            conv_start <= next_conv_start;
            conv_pos <= next_conv_pos;
            conv_neg <= next_conv_neg;
            conv_diff <= next_conv_diff;
            result_valid <= next_result_valid;
            result_data <= next_result_data;
            result_seq <= next_result_seq;
            comparator_trigger <= next_comp_trig;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_issue_diff;
        ce && state == ACS_ISSUE && seq_ctl[cur][step];
    endsequence
    sequence s_grant;
        ce && state == ACS_IDLE && |pend;
    endsequence

    pair_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_issue_diff ##0 (field[3:2] == 2'b00) |=> conv_pos == {1'b0, $past(field[1:0]), 1'b0})
        else $error("lower differential pair decoded wrongly");
    pair_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_issue_diff ##0 (field[3:2] == 2'b10) |=> conv_pos == {1'b1, $past(field[1:0]), 1'b0}
        && conv_neg == conv_pos + 4'd1) else $error("upper differential pair decoded wrongly");
    cont_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && retrig && seq_en[cur] |=> cont[$past(cur)]) else $error("retrigger did not make sampling continuous");
    cont_type_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && state != ACS_IDLE && hit[cur] && cur_type != start_type |=> pend[$past(cur)])
        else $error("retrigger of another type was not queued");
    last_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && step_done && step == last_step |=> comparator_trigger == 4'h0)
        else $error("last step comparator fired");
    seq3_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        cur == 2'd3 && state != ACS_IDLE |-> step == 3'h0 && last_step == 3'h0)
        else $error("sequencer three ran more than one step");
    cmp_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && step_done && step != last_step && seq_ctl[cur][`ACS_CTL_CMP_POS + 32'(step) + 1]
        && !thresh[`ACS_THR_MODE_POS] && conv_data >= thresh[11:0] |=> comparator_trigger[$past(cur)])
        else $error("next step comparator did not judge the result");
    arb_defect_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_grant ##0 pend == 4'hC |=> cur == (($past(pri[3:2]) < $past(pri[5:4])) ? 2'd2 : 2'd3) ##1 conv_start)
        else $error("defective arbitration not reproduced");
    arb_pri_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_grant ##0 pend == 4'h3 && pri[1:0] < pri[3:2] |=> cur == 2'd0) else $error("priority order violated");
endmodule
`default_nettype wire

// ---- acs_conv_model.sv ----
// Purpose: Converter model that answers each conv_start with one conv_done.
// Assumes: One conversion outstanding; answer LAT cycles after the start pulse.
// Notes:   Data between answers toggles so that a stale sample never looks valid.
`default_nettype none
module acs_conv_model
    import acs_pkg::*;
#(
    parameter int LAT = 3
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       conv_start,
    input  wire logic [3:0] conv_pos,
    output logic            conv_done,
    output acs_sample_t     conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= 0;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            conv_done <= (cnt == 1);
            conv_data <= (cnt == 1) ? {4'hA, conv_pos, 4'h5} : ~conv_data;
            cnt       <= conv_start ? LAT : ((cnt > 0) ? cnt - 1 : 0);
        end
    end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench of the sequencer control block.
// Assumes: Threshold 0 makes every judged result fire its comparator.
// Notes:   Only the timer trigger is driven; other trigger inputs stay low.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} acs_row_s;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, dif;
    logic        timer_trig, conv_start, conv_diff, conv_done, result_valid, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  conv_pos, conv_neg, comparator_trigger, pos, neg;
    logic [11:0] conv_data, result_data, res;
    logic [1:0]  result_seq;
    logic [1:0]  seqs [$];
    int          mismatches, n_tests, cycles, n_start, n_res, n_cmp, t_start, t0, b;
    acs_row_s    rows [6] = '{'{0, 8'h18, 0, 32'hE4, 0}, '{1'b1, 8'h1C, 3, 0, 0}, '{0, 8'h1C, 0, 3, 0},
                              '{0, 8'hFC, 0, 0, 1}, '{0, 8'h0C, 0, 0, 0}, '{1, 8'h20, 0, 0, 0}};
    acs_top dut_u (.*, .comp_trig_in(1'b0), .ext_trig_pin(1'b0), .pwm_trigger(1'b0));
    acs_conv_model conv_u (.pclk(pclk), .presetn(presetn), .conv_start(conv_start), .conv_pos(conv_pos),
                           .conv_done(conv_done), .conv_data(conv_data));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (conv_start === 1'b1) begin
            n_start <= n_start + 1;
            t_start <= cycles;
            pos     <= conv_pos;
            neg     <= conv_neg;
            dif     <= conv_diff;
        end
        if (result_valid === 1'b1) begin
            n_res <= n_res + 1;
            res   <= result_data;
            seqs.push_back(result_seq);
        end
        if (comparator_trigger !== 4'h0) n_cmp <= n_cmp + 1;
        if (cycles == 30000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The idle edge after each transfer keeps two writes of psel out of one time step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic conclude();
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {presetn, ce, psel, penable, pwrite, paddr, pwdata, timer_trig} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        ce      <= 1'b1;
        @(posedge pclk);
        chk(irq, 0);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].x);
            chk(err, rows[i].e);
        end
        apb(1, 8'h00, 32'h1);
        apb(1, 8'h10, 32'hFFF0);
        apb(1, 8'h44, 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1, 8'h1C, i);
            apb(1, 8'h40, (i < 4) ? i : i + 4);
            t0 = cycles;
            b = n_res;
            apb(1, 8'h14, 32'h1);
            while (n_res < b + 1) @(posedge pclk);
            chk(t_start - t0, 5);
            chk(res, {4'hA, 4'(2 * i), 4'h5});
            chk(pos, 2 * i);
            chk(neg, 2 * i + 1);
            chk(dif, 1);
        end
        for (int i = 0; i < 2; i++) begin
            b = n_cmp;
            t0 = n_res;
            apb(1, 8'h44, i ? 32'h0101_0000 : 32'h0201_0000);
            apb(1, 8'h14, 32'h1);
            while (n_res < t0 + 2) @(posedge pclk);
            chk(n_cmp - b, 1 - i);
        end
        apb(1, 8'h00, 32'h8);
        apb(1, 8'h10, 32'h0FFF);
        apb(1, 8'h0C, 32'hFF);
        apb(1, 8'h5C, 32'h0101_0100);
        b = n_start;
        t0 = n_cmp;
        apb(1, 8'h14, 32'h8);
        repeat (40) @(posedge pclk);
        chk(n_start - b, 1);
        chk(n_cmp - t0, 0);
        apb(0, 8'h04, 0);
        chk(rd, 32'h8);
        chk(irq, 0);
        apb(1, 8'h08, 32'h8);
        @(posedge pclk);
        chk(irq, 1);
        apb(1, 8'h0C, 32'h8);
        @(posedge pclk);
        chk(irq, 0);
        apb(1, 8'h00, 32'hC);
        apb(1, 8'h10, 32'h3377);
        apb(1, 8'h54, 32'h0);
        for (int i = 0; i < 2; i++) begin
            apb(1, 8'h18, i ? 32'h9C : 32'h63);
            b = n_res;
            timer_trig <= 1'b1;
            @(posedge pclk);
            timer_trig <= 1'b0;
            while (n_res < b + 2) @(posedge pclk);
            chk(seqs[b], 2 + i);
        end
        apb(1, 8'h00, 32'h3);
        apb(1, 8'h10, 32'h7700);
        for (int i = 0; i < 2; i++) begin
            apb(1, 8'h18, i ? 32'hE4 : 32'hE1);
            b = n_res;
            apb(1, 8'h14, 32'h3);
            while (n_res < b + 3) @(posedge pclk);
            chk(seqs[b], 1 - i);
        end
        apb(1, 8'h00, 32'h1);
        apb(1, 8'h44, 32'h0003_0000);
        b = n_res;
        apb(1, 8'h14, 32'h1);
        apb(1, 8'h14, 32'h1);
        repeat (100) @(posedge pclk);
        chk(n_res - b >= 9, 1);
        apb(1, 8'h00, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
